/* File: hdl/lane_port_defines.vh */
// Constants for the lane-to-port configuration block
`ifndef LANE_PORT_DEFINES_VH
`define LANE_PORT_DEFINES_VH
`define NUM_QUADS 10
`define NUM_LANES 40
`define NUM_PORTS 16
`define ENH_QUAD_A 4
`define ENH_QUAD_B 9
`define RATE_1G25 2'h0
`define RATE_2G5 2'h1
`define RATE_3G125 2'h2
`define RATE_RSVD 2'h3
`define MODE_4X 2'h0
`define MODE_1X_L0 2'h1
`define MODE_1X_L2 2'h2
`define MODE_4X1X 2'h3
`define STATUS_PERIOD 11'h400
`define STATUS_CNT_W 11
`define CG_IDLE 2'h0
`define CG_START 2'h1
`define CG_END 2'h2
`define CG_STATUS 2'h3
`define REF_CLK_KHZ 156250
`define CORE_CLK_MULT 2
`endif

/* File: hdl/tx_symbol_pacer.v */
// Transmit control-symbol pacer for one quad
`timescale 1ns/1ps
`default_nettype none
`include "lane_port_defines.vh"
module tx_symbol_pacer (
  input wire clock_i, // Core clock
  input wire srst_i, // Synchronous reset, active high
  input wire pkt_start_i, // Request to open a packet
  input wire pkt_end_i, // Request to close a packet
  input wire data_i, // Data code-group wanted
  output reg [1:0] cg_kind_o, // Code-group kind sent this cycle
  output wire busy_o // Status symbol steals this slot
);
  reg [`STATUS_CNT_W-1:0] cnt_ff;
  reg [`STATUS_CNT_W-1:0] nxt_cnt;
  reg [1:0] nxt_kind;
  wire status_due;
  // Force status one slot before the limit so the gap never exceeds it
  assign status_due = (cnt_ff == `STATUS_PERIOD - 11'h001);
  assign busy_o = status_due;
  always @*
  begin
    nxt_cnt = cnt_ff + 11'h001;
    nxt_kind = `CG_IDLE;
    if (status_due)
    begin
      nxt_kind = `CG_STATUS;
      nxt_cnt = 11'h000;
    end
    else if (pkt_start_i)
      nxt_kind = `CG_START;
    else if (pkt_end_i)
      nxt_kind = `CG_END;
    else if (data_i)
      nxt_kind = `CG_IDLE;
  end
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cnt_ff <= 11'h000;
      cg_kind_o <= `CG_IDLE;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      cg_kind_o <= nxt_kind;
    end
  end
endmodule // tx_symbol_pacer
`default_nettype wire

/* File: hdl/lane_port_config.v */
// Lane-to-port configuration for a 40-lane serial packet switch
`timescale 1ns/1ps
`default_nettype none
`include "lane_port_defines.vh"
module lane_port_config (
  input wire clock_i, // Core clock, twice the reference
  input wire srst_i, // Synchronous reset, active high
  input wire [1:0] line_rate_select_pins_i, // Static rate straps
  input wire quad_ctrl_wr_i, // Write strobe for quad control
  input wire [3:0] quad_ctrl_sel_i, // Quad being written
  input wire [1:0] quad_ctrl_mode_i, // Lane mode for that quad
  input wire [1:0] quad_ctrl_rate_i, // Line rate for that quad
  input wire [`NUM_QUADS-1:0] pkt_start_i, // Per quad packet start
  input wire [`NUM_QUADS-1:0] pkt_end_i, // Per quad packet end
  input wire [`NUM_QUADS-1:0] data_i, // Per quad data wanted
  input wire [`NUM_QUADS-1:0] err_event_i, // Internal error events
  input wire err_clear_i, // Clears the error flag
  output reg [2*`NUM_QUADS-1:0] quad_mode_o, // Mode per quad
  output reg [2*`NUM_QUADS-1:0] quad_rate_o, // Rate per quad
  output reg [`NUM_LANES-1:0] lane_active_o, // Lanes carrying a link
  output reg [`NUM_LANES-1:0] lane_port_start_o, // Lane is a port's first lane
  output reg [4:0] port_count_o, // Number of ports formed
  output reg [2*`NUM_QUADS-1:0] cg_kind_o, // Code-group kind per quad
  output reg cfg_err_o, // Rejected configuration write
  output wire irq_n_o, // Open-drain interrupt, output value
  output wire irq_oe_n_o // Low while the interrupt is driven low
);
  reg [2*`NUM_QUADS-1:0] mode_ff;
  reg [2*`NUM_QUADS-1:0] rate_ff;
  reg strap_done_ff;
  reg err_ff;
  reg [1:0] strap_rate;
  wire [2*`NUM_QUADS-1:0] pace_kind;
  wire wr_rsvd_rate;
  wire wr_bad_mode;
  wire wr_bad_sel;
  wire wr_ok;
  integer q;
  reg [4:0] cnt;
  wire wr_reject;
  wire any_event;
  wire strap_bad;
  wire [`NUM_QUADS-1:0] split_q;
  // Reserved strap code falls back to the slowest rate rather than hang
  always @*
  begin
    if (line_rate_select_pins_i == `RATE_RSVD)
      strap_rate = `RATE_1G25;
    else
      strap_rate = line_rate_select_pins_i;
  end
  assign wr_bad_sel = (quad_ctrl_sel_i >= `NUM_QUADS);
  assign wr_rsvd_rate = (quad_ctrl_rate_i == `RATE_RSVD);
  // Split mode is only legal on the two enhanced quads
  assign wr_bad_mode = (quad_ctrl_mode_i == `MODE_4X1X) && (quad_ctrl_sel_i != `ENH_QUAD_A)
    && (quad_ctrl_sel_i != `ENH_QUAD_B);
  assign wr_ok = quad_ctrl_wr_i && !wr_bad_sel && !wr_rsvd_rate && !wr_bad_mode;
  // A write on the strap capture edge would be overwritten, so refuse it openly
  assign wr_reject = quad_ctrl_wr_i && (!wr_ok || !strap_done_ff);
  assign any_event = |err_event_i;
  // Reserved strap code is an error the host must hear about
  assign strap_bad = !strap_done_ff && (line_rate_select_pins_i == `RATE_RSVD);
  // Straps caught on the first clock after reset release
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      mode_ff <= 20'h00000;
      rate_ff <= 20'h00000;
      strap_done_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_done_ff <= 1'b1;
      rate_ff <= {`NUM_QUADS{strap_rate}};
    end
    else if (wr_ok)
    begin
      mode_ff[2*quad_ctrl_sel_i +: 2] <= quad_ctrl_mode_i;
      rate_ff[2*quad_ctrl_sel_i +: 2] <= quad_ctrl_rate_i;
    end
  end
  // Lane map per quad
  genvar g;
  generate
    for (g = 0; g < `NUM_QUADS; g = g + 1)
    begin : quad_g
      assign split_q[g] = (mode_ff[2*g +: 2] == `MODE_4X1X);
      always @(posedge clock_i)
      begin
        if (srst_i)
        begin
          lane_active_o[4*g +: 4] <= 4'h0;
          lane_port_start_o[4*g +: 4] <= 4'h0;
        end
        else
        begin
          case (mode_ff[2*g +: 2])
            `MODE_4X:
            begin
              lane_active_o[4*g +: 4] <= 4'hF;
              lane_port_start_o[4*g +: 4] <= 4'h1;
            end
            `MODE_1X_L0:
            begin
              lane_active_o[4*g +: 4] <= 4'h1;
              lane_port_start_o[4*g +: 4] <= 4'h1;
            end
            `MODE_1X_L2:
            begin
              lane_active_o[4*g +: 4] <= 4'h4;
              lane_port_start_o[4*g +: 4] <= 4'h4;
            end
            `MODE_4X1X:
            begin
              lane_active_o[4*g +: 4] <= 4'hF;
              lane_port_start_o[4*g +: 4] <= 4'hF;
            end
            default:
            begin
              lane_active_o[4*g +: 4] <= 4'h0;
              lane_port_start_o[4*g +: 4] <= 4'h0;
            end
          endcase
        end
      end
      tx_symbol_pacer pacer_u (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pkt_start_i(pkt_start_i[g]),
        .pkt_end_i(pkt_end_i[g]),
        .data_i(data_i[g]),
        .cg_kind_o(pace_kind[2*g +: 2]),
        .busy_o()
      );
    end
  endgenerate
  // Port count: ten quads plus three extra per split quad, max sixteen
  always @*
  begin
    cnt = 5'h0A;
    for (q = 0; q < `NUM_QUADS; q = q + 1)
      if (split_q[q])
        cnt = cnt + 5'h03;
  end
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      quad_mode_o <= 20'h00000;
      quad_rate_o <= 20'h00000;
      port_count_o <= 5'h0A;
      cg_kind_o <= 20'h00000;
    end
    else
    begin
      quad_mode_o <= mode_ff;
      quad_rate_o <= rate_ff;
      port_count_o <= cnt;
      cg_kind_o <= pace_kind;
    end
  end
  // Sticky error flag: a new error wins over a clear in the same cycle
  always @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cfg_err_o <= 1'b0;
      err_ff <= 1'b0;
    end
    else
    begin
      cfg_err_o <= wr_reject;
      if (any_event || wr_reject || strap_bad)
        err_ff <= 1'b1;
      else if (err_clear_i)
        err_ff <= 1'b0;
    end
  end
  // Open drain: pull low on error, otherwise released
  assign irq_n_o = 1'b0;
  assign irq_oe_n_o = !err_ff;
endmodule // lane_port_config
`default_nettype wire

/* File: tb/lane_port_config_assertions.sv */
// Port assertions for the lane-to-port configuration block
`timescale 1ns/1ps
`default_nettype none
module lane_port_checker (
  input wire logic clock_i, srst_i, quad_ctrl_wr_i, err_clear_i, cfg_err_o, irq_n_o, irq_oe_n_o,
  input wire logic [3:0] quad_ctrl_sel_i,
  input wire logic [1:0] quad_ctrl_mode_i, quad_ctrl_rate_i,
  input wire logic [9:0] pkt_start_i, err_event_i,
  input wire logic [19:0] quad_rate_o, cg_kind_o,
  input wire logic [4:0] port_count_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic [10:0] gap_ff;
  wire ok_wr = quad_ctrl_sel_i < 4'hA && quad_ctrl_rate_i != 2'h3 &&
    (quad_ctrl_mode_i != 2'h3 || quad_ctrl_sel_i == 4'h4 || quad_ctrl_sel_i == 4'h9);
  // Cycles since quad 0 last sent a status symbol
  always @(posedge clock_i) gap_ff <= (srst_i || cg_kind_o[1:0] == 2'h3) ? 11'h0 : gap_ff + 11'h1;
  sequence start_out;
    ##2 cg_kind_o[1:0] inside {2'h1, 2'h3};
  endsequence
  irq_value_a: assert property (!irq_n_o) else $error("irq value");
  event_irq_a: assert property (|err_event_i |=> !irq_oe_n_o) else $error("event irq");
  clear_irq_a: assert property (err_clear_i && !err_event_i && !quad_ctrl_wr_i && !$past(srst_i) |=> irq_oe_n_o)
    else $error("clear irq");
  reject_wr_a: assert property (quad_ctrl_wr_i && !ok_wr |=> cfg_err_o && !irq_oe_n_o) else $error("reject");
  rate_wr_a: assert property (quad_ctrl_wr_i && ok_wr && !$past(srst_i) |=> ##1
    2'(quad_rate_o >> 2*$past(quad_ctrl_sel_i, 2)) == $past(quad_ctrl_rate_i, 2)) else $error("rate");
  port_count_a: assert property (port_count_o inside {[5'hA:5'h10]}) else $error("ports");
  start_pace_a: assert property (pkt_start_i[0] |-> start_out) else $error("start");
  status_gap_a: assert property (gap_ff <= 11'h403) else $error("status gap");
endmodule // lane_port_checker
bind lane_port_config lane_port_checker lane_port_checker_i (.clock_i, .srst_i, .quad_ctrl_wr_i, .err_clear_i,
  .cfg_err_o, .irq_n_o, .irq_oe_n_o, .quad_ctrl_sel_i, .quad_ctrl_mode_i, .quad_ctrl_rate_i, .pkt_start_i,
  .err_event_i, .quad_rate_o, .cg_kind_o, .port_count_o);
`default_nettype wire

/* File: tb/pkt_source.sv */
// Packet requester model for the transmit side of quad 0
`timescale 1ns/1ps
`default_nettype none
module pkt_source (
  input wire logic clock_i, // Core clock
  input wire logic go_i, // Rising edge sends a packet
  input wire logic [1:0] cg_i, // Kind sent by quad 0
  output logic start_o, // Open request
  output logic end_o, // Close request
  output logic data_o, // Data request
  output logic [7:0] sent_o // Packets done
);
  logic seen;
  initial {start_o, end_o, data_o, sent_o} = 11'h0;
  // A status symbol may steal the slot, so ask again
  task put(input logic [1:0] kind);
    seen = 1'b0;
    while (!seen)
    begin
      @(posedge clock_i) #1 {start_o, end_o} = {kind == 2'h1, kind == 2'h2};
      @(posedge clock_i) #1 {start_o, end_o} = 2'h0;
      repeat (3) @(posedge clock_i) #1 seen = seen | (cg_i == kind);
    end
  endtask
  always @(posedge go_i)
  begin
    put(2'h1);
    @(posedge clock_i) #1 data_o = 1'b1;
    @(posedge clock_i) #1 data_o = 1'b0;
    put(2'h2);
    sent_o = sent_o + 8'h1;
  end
endmodule // pkt_source
`default_nettype wire

/* File: tb/tb_lane_port_config.sv */
// Bench for the lane-to-port configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_lane_port_config;
  logic clock_i = 0, srst_i = 1, wr = 0, clr = 0, go = 0;
  logic [1:0] pins = 2'h2, md = 2'h0, rt = 2'h0;
  logic [3:0] sel = 4'h0;
  logic [9:0] ev = 10'h0;
  wire [19:0] qm, qr, cg;
  wire [39:0] act, fst;
  wire [4:0] pc;
  wire [7:0] sent;
  wire st, en, dt, ce, iv, ioe;
  wire pin = ioe ? 1'b1 : iv; // Pull-up wins while released
  int fails = 0, comparisons = 0, cyc = 0, starts = 0, ends = 0, stats = 0;
  always #50 clock_i = ~clock_i;
  lane_port_config lane_port_config_i (.clock_i, .srst_i, .line_rate_select_pins_i(pins), .quad_ctrl_wr_i(wr),
    .quad_ctrl_sel_i(sel), .quad_ctrl_mode_i(md), .quad_ctrl_rate_i(rt), .pkt_start_i({9'h0, st}),
    .pkt_end_i({9'h0, en}), .data_i({9'h0, dt}), .err_event_i(ev), .err_clear_i(clr), .quad_mode_o(qm),
    .quad_rate_o(qr), .lane_active_o(act), .lane_port_start_o(fst), .port_count_o(pc), .cg_kind_o(cg),
    .cfg_err_o(ce), .irq_n_o(iv), .irq_oe_n_o(ioe));
  pkt_source pkt_source_i (.clock_i, .go_i(go), .cg_i(cg[1:0]), .start_o(st), .end_o(en), .data_o(dt), .sent_o(sent));
  always @(posedge clock_i) cyc <= cyc + 1;
  always @(posedge clock_i) starts <= starts + (cg[1:0] == 2'h1);
  always @(posedge clock_i) ends <= ends + (cg[1:0] == 2'h2);
  always @(posedge clock_i) stats <= stats + (cg[1:0] == 2'h3);
  always @(posedge clock_i) if (cyc == 4000) end_sim(1);
  task end_sim(input int extra);
    fails += extra;
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr_q(input logic [3:0] q, input logic [1:0] m, input logic [1:0] r);
    @(posedge clock_i) #1 {sel, md, rt, wr} = {q, m, r, 1'b1};
    @(posedge clock_i) #1 wr = 1'b0;
  endtask
  task set_q(input logic [3:0] q, input logic [1:0] m, r, input logic [3:0] a, f, input logic [4:0] n);
    wr_q(q, m, r);
    repeat (2) @(posedge clock_i);
    #1 chk("mode", qm[2*q+:2], m);
    chk("rate", qr[2*q+:2], r);
    chk("lanes", act[4*q+:4], a);
    chk("first", fst[4*q+:4], f);
    chk("ports", pc, n);
  endtask
  task clr_irq;
    @(posedge clock_i) #1 clr = 1'b1;
    @(posedge clock_i) #1 clr = 1'b0;
    @(posedge clock_i) #1 chk("irq_clear", pin, 1'b1);
  endtask
  task bad_q(input logic [3:0] q, input logic [1:0] m, r);
    logic [19:0] was;
    was = qm;
    wr_q(q, m, r);
    chk("reject", ce, 1'b1);
    chk("irq_set", pin, 1'b0);
    @(posedge clock_i) #1 chk("kept", qm, was);
    clr_irq();
  endtask
  task do_reset(input logic [1:0] p);
    @(posedge clock_i) #1 {srst_i, pins} = {1'b1, p};
    repeat (5) @(posedge clock_i);
    #1 srst_i = 1'b0;
    repeat (3) @(posedge clock_i);
    #1 chk("mode_rst", qm, 20'h0);
    chk("rate_rst", qr, {10{p == 2'h3 ? 2'h0 : p}});
    chk("ports_rst", pc, 5'hA);
    chk("lanes_rst", act, {40{1'b1}});
    chk("first_rst", fst, {10{4'h1}});
    chk("irq_rst", pin, p != 2'h3);
  endtask
  initial
  begin
    do_reset(2'h2);
    set_q(4'h0, 2'h1, 2'h1, 4'h1, 4'h1, 5'hA);
    set_q(4'h1, 2'h2, 2'h0, 4'h4, 4'h4, 5'hA);
    set_q(4'h4, 2'h3, 2'h2, 4'hF, 4'hF, 5'hD);
    set_q(4'h9, 2'h3, 2'h1, 4'hF, 4'hF, 5'h10);
    set_q(4'h9, 2'h0, 2'h2, 4'hF, 4'h1, 5'hD);
    bad_q(4'h2, 2'h3, 2'h0);
    bad_q(4'h0, 2'h1, 2'h3);
    bad_q(4'hA, 2'h0, 2'h0);
    @(posedge clock_i) #1 ev = 10'h020;
    @(posedge clock_i) #1 ev = 10'h000;
    chk("event", pin, 1'b0);
    clr_irq();
    @(posedge clock_i) #1 go = 1'b1;
    for (int i = 0; i < 60 && sent == 8'h0; i++) @(posedge clock_i) #1 go = 1'b0;
    // Long enough for a full status period
    repeat (1100) @(posedge clock_i);
    #1 chk("starts", starts, 1);
    chk("ends", ends, 1);
    chk("status", stats > 0, 1'b1);
    do_reset(2'h3);
    end_sim(0);
  end
endmodule // tb_lane_port_config
`default_nettype wire
